// File: key_detect.sv
// input synchroniser and edge / level detector for the key lanes
`timescale 1ns/1ps
module key_detect
  import key_wakeup_pkg::*;
#(
  parameter int N = LANES
)(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    rst_b,
  // raw key lanes
  input  wire logic [N-1:0] lane_raw,
  // control side
  key_detect_if.det    dif
);
  import key_wakeup_pkg::*;

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;
  logic         armed_q;
  logic [N-1:0] now_asserted;
  logic [N-1:0] rising;
  logic         any_rising;

  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= lane_raw;
      sync_q <= meta_q;
    end

  // ---------------------------------------------------------------
  // polarity and enable
  // ---------------------------------------------------------------
  assign now_asserted = ~(sync_q ^ dif.polarity_sel[N-1:0])
                        & dif.pin_enable_x[N-1:0];
  assign rising       = now_asserted & ~prev_q;
  assign any_rising   = |rising;

  assign dif.asserted  = lane_vec_t'(now_asserted);
  assign dif.level_any = |now_asserted;
  assign dif.edge_seen = armed_q & any_rising;

  // ---------------------------------------------------------------
  // previous sample and re-arm
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      prev_q  <= '0;
      armed_q <= 1'b1;
    end
    else if (dif.det_clear)
    begin
      prev_q  <= '0;
      armed_q <= 1'b1;
    end
    else
    begin
      prev_q <= now_asserted;
      if (armed_q && any_rising)
        armed_q <= 1'b0;
      else if (~|now_asserted)
        armed_q <= 1'b1;
    end

endmodule

// File: key_detect_if.sv
// configuration and detection signals between control and detector
`timescale 1ns/1ps
interface key_detect_if;
  import key_wakeup_pkg::*;

  lane_vec_t pin_enable_x;
  lane_vec_t polarity_sel;
  logic      det_clear;
  lane_vec_t asserted;
  logic      edge_seen;
  logic      level_any;

  modport ctrl (
    output pin_enable_x,
    output polarity_sel,
    output det_clear,
    input  asserted,
    input  edge_seen,
    input  level_any
  );

  modport det (
    input  pin_enable_x,
    input  polarity_sel,
    input  det_clear,
    output asserted,
    output edge_seen,
    output level_any
  );
endinterface

// File: key_switch_model.sv
// key switch lines as seen from outside the block
`timescale 1ns/1ps
module key_switch_model (
  // clock
  input wire logic  core_clk,
  // requested switch levels
  input wire logic [3:0] press,
  // pin levels
  output logic [3:0] key_lines
);
  initial key_lines = 4'hF;
  // switches settle on a clock edge, like any other bench input
  always @(posedge core_clk)
    key_lines <= press;
endmodule

// File: key_wakeup_checker.sv
// port assertions for the key wake-up interrupt block
`timescale 1ns/1ps
module key_wakeup_checker
  import key_wakeup_pkg::*;
(
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rst_b,
  // wishbone
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // modes and outputs
  input wire logic             wait_mode,
  input wire logic             deep_stop,
  input wire logic             irq_o,
  input wire logic             wake_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // shadow of the interrupt gates, from completed writes
  logic ie_q;
  logic ie_d;
  logic mask_q;
  logic mask_d;
  wire  wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign ie_d = deep_stop ? 1'h0 :
    (wr_ok && wb_adr_i == OFS_CTRL) ? wb_dat_i[BIT_IE] : ie_q;
  assign mask_d = deep_stop ? 1'h0 :
    (wr_ok && wb_adr_i == OFS_MASK) ? |wb_dat_i[1:0] : mask_q;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      ie_q   <= 1'h0;
      mask_q <= 1'h0;
    end
    else
    begin
      ie_q   <= ie_d;
      mask_q <= mask_d;
    end

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !deep_stop |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_ctrl_fixed: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_CTRL
    |-> wb_dat_o[7:4] == 4'h0 && !wb_dat_o[BIT_ACK])
    else $error("control read shows ack or upper bits");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_irq_gated: assert property (!ie_q && !mask_q |-> !irq_o)
    else $error("irq while every gate is off");
  chk_irq_flag: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_CTRL
    && wb_dat_o[BIT_IE] && wb_dat_o[BIT_FLAG] |-> irq_o)
    else $error("flag and enable set but no irq");
  chk_irq_holds: assert property (
    irq_o && !wb_ack_o && !deep_stop |=> irq_o)
    else $error("irq dropped without a write");
  chk_deep_quiet: assert property (deep_stop |=> !irq_o && !wake_o)
    else $error("output active in deep stop");
  chk_wait_wake: assert property (wait_mode && irq_o |-> wake_o)
    else $error("no wake in wait with irq");
endmodule

bind key_wakeup_interrupt key_wakeup_checker key_wakeup_checker_inst (
  .core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wait_mode, .deep_stop,
  .irq_o, .wake_o
);

// File: key_wakeup_interrupt.sv
// key wake-up interrupt block with classic wishbone register slave
`timescale 1ns/1ps
module key_wakeup_interrupt
  import key_wakeup_pkg::*;
#(
  parameter int NUM_PINS = PINS
)(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // key pins
  input  wire logic [NUM_PINS-1:0] key_inputs_0_to_3,
  // power modes
  input  wire logic                wait_mode,
  input  wire logic                light_stop_mode,
  input  wire logic                deep_stop,
  input  wire logic                debug_halt,
  // interrupt and wake
  output logic                     irq_o,
  output logic                     wake_o
);
  import key_wakeup_pkg::*;

  key_detect_if dif ();

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lane_vec_t         pen_q;
  lane_vec_t         pol_q;
  logic              mode_q;
  logic              ie_q;
  logic              flag_q;
  logic [EVT_W-1:0]  evt_q;
  logic [EVT_W-1:0]  mask_q;
  logic              ack_q;
  logic [31:0]       rdat_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        req      = wb_cyc_i & wb_stb_i;
  wire        wr_fire  = req & ack_q & wb_we_i & wb_sel_i[0];
  wire        rd_take  = req & ~ack_q;
  wire        hit_ctrl = (wb_adr_i == OFS_CTRL);
  wire        hit_pen  = (wb_adr_i == OFS_PEN);
  wire        hit_pol  = (wb_adr_i == OFS_POL);
  wire        hit_evt  = (wb_adr_i == OFS_EVT);
  wire        hit_mask = (wb_adr_i == OFS_MASK);
  wire [7:0]  wbyte    = wb_dat_i[7:0];

  wire        wr_ctrl  = wr_fire & hit_ctrl;
  wire        wr_pen   = wr_fire & hit_pen;
  wire        wr_pol   = wr_fire & hit_pol;
  wire        wr_evt   = wr_fire & hit_evt;
  wire        wr_mask  = wr_fire & hit_mask;
  wire        ack_req  = wr_ctrl & wbyte[BIT_ACK];

  // control read: ack reads 0, upper nibble reads 0
  wire [7:0]  ctrl_rd  = {4'h0, flag_q, 1'b0, ie_q, mode_q};

  logic [7:0] rd_mux;
  always_comb
  begin
    if (hit_ctrl)
      rd_mux = ctrl_rd;
    else if (hit_pen)
      rd_mux = pen_q;
    else if (hit_pol)
      rd_mux = pol_q;
    else if (hit_evt)
      rd_mux = {6'h00, evt_q};
    else if (hit_mask)
      rd_mux = {6'h00, mask_q};
    else
      rd_mux = 8'h00;
  end

  // ---------------------------------------------------------------
  // lane wiring: only the real pins are ever seen
  // ---------------------------------------------------------------
  lane_vec_t lane_raw;
  lane_vec_t lane_ok;
  assign lane_raw = lane_vec_t'(key_inputs_0_to_3);
  assign lane_ok  = lane_vec_t'({NUM_PINS{1'b1}});

  // deep stops hold the registers in reset and clear the detector; the bus answer keeps running
  wire off = deep_stop;

  assign dif.pin_enable_x = pen_q & lane_ok;
  assign dif.polarity_sel = pol_q;
  assign dif.det_clear    = off;

  key_detect #(
    .N        (LANES)
  ) u_det (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .lane_raw (lane_raw),
    .dif      (dif.det)
  );

  // ---------------------------------------------------------------
  // flag set and clear
  // ---------------------------------------------------------------
  // debug halt does not gate detection; it runs as in run mode
  wire run_ok    = ~off | debug_halt & ~off;
  wire level_hit = mode_q & dif.level_any;
  wire flag_set  = run_ok & (dif.edge_seen | level_hit);
  wire held      = mode_q & dif.level_any;
  wire flag_clr  = ack_req & ~held;
  wire flag_d    = flag_set | (flag_q & ~flag_clr);

  // ---------------------------------------------------------------
  // event status: detection and refused acknowledge
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] evt_hit;
  assign evt_hit[EVT_DETECT] = flag_set & ~flag_q;
  assign evt_hit[EVT_HELD]   = ack_req & held;
  wire [EVT_W-1:0] evt_d = evt_hit
                         | (evt_q & ~({EVT_W{wr_evt}} & wbyte[EVT_W-1:0]));

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      pen_q  <= RST_PEN;
      pol_q  <= RST_POL;
      mode_q <= RST_MODE;
      ie_q   <= RST_IE;
      flag_q <= RST_FLAG;
      evt_q  <= RST_EVT;
      mask_q <= RST_MASK;
    end
    else if (off)
    begin
      pen_q  <= RST_PEN;
      pol_q  <= RST_POL;
      mode_q <= RST_MODE;
      ie_q   <= RST_IE;
      flag_q <= RST_FLAG;
      evt_q  <= RST_EVT;
      mask_q <= RST_MASK;
    end
    else
    begin
      flag_q <= flag_d;
      evt_q  <= evt_d;
      if (wr_ctrl)
      begin
        mode_q <= wbyte[BIT_MODE];
        ie_q   <= wbyte[BIT_IE];
      end
      if (wr_pen)
        pen_q <= wbyte;
      if (wr_pol)
        pol_q <= wbyte;
      if (wr_mask)
        mask_q <= wbyte[EVT_W-1:0];
    end

  // ---------------------------------------------------------------
  // bus answer: one wait state, ack for one cycle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= rd_take;
      if (rd_take)
        rdat_q <= {24'h00_0000, rd_mux};
    end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------
  // interrupt and wake
  // ---------------------------------------------------------------
  wire key_req  = ie_q & flag_q;
  wire evt_req  = |(evt_q & mask_q);
  assign irq_o  = key_req | evt_req;

  // clockless path: raw pin levels, used only while the clock is off
  wire [NUM_PINS-1:0] raw_act =
    ~(key_inputs_0_to_3 ^ pol_q[NUM_PINS-1:0]) & pen_q[NUM_PINS-1:0];
  wire stop_wake = light_stop_mode & ie_q & (|raw_act);
  wire wait_wake = wait_mode & irq_o;
  assign wake_o  = ~off & (stop_wake | wait_wake);

endmodule

// File: key_wakeup_interrupt_tb.sv
// self-checking bench for the key wake-up interrupt block
`timescale 1ns/1ps
module key_wakeup_interrupt_tb;
  import key_wakeup_pkg::*;
  typedef struct packed {
    logic [7:0] pen;
    logic [7:0] pol;
    logic       mode;
    logic [3:0] idle;
    logic [3:0] act;
    logic       f1;
    logic       f2;
  } row_t;
  // enable, polarity, mode, idle, active, flag, flag after ack
  localparam row_t ROWS [5] = '{
    '{8'h0F, 8'h00, 1'h0, 4'hF, 4'hE, 1'h1, 1'h0},
    '{8'h0F, 8'h0F, 1'h0, 4'h0, 4'h8, 1'h1, 1'h0},
    '{8'h02, 8'h00, 1'h0, 4'hF, 4'hE, 1'h0, 1'h0},
    '{8'h0F, 8'h05, 1'h0, 4'hA, 4'hB, 1'h1, 1'h0},
    '{8'h0F, 8'h00, 1'h1, 4'hF, 4'h7, 1'h1, 1'h1}};
  logic core_clk = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, wait_mode = 1'h0, light_stop_mode = 1'h0;
  logic deep_stop = 1'h0, debug_halt = 1'h0, irq_o, wake_o, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF, press = 4'hF, key_lines;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  int mismatches = 0, checks = 0;
  row_t r;
  always #50 core_clk = ~core_clk;
  key_switch_model key_switch_model_inst (.core_clk, .press, .key_lines);
  key_wakeup_interrupt key_wakeup_interrupt_inst (.core_clk, .rst_b,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .key_inputs_0_to_3(key_lines), .wait_mode,
    .light_stop_mode, .deep_stop, .debug_halt, .irq_o, .wake_o);

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 20)
    begin
      mismatches++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd_check(input string nm, input logic [7:0] a, e);
    logic [7:0] g;
    bus(1'h0, a, 8'h00, g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_bit(input string nm, input logic e, input bit wake);
    logic g;
    @(negedge core_clk);
    g = wake ? wake_o : irq_o;
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task complete_run;
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    mismatches++;
    complete_run;
  end
  initial
  begin
    tick(2);
    rst_b <= 1'h1;
    for (int i = 0; i < 5; i++)
    begin
      r = ROWS[i];
      debug_halt <= (i == 3);
      press <= r.idle;
      wr(OFS_PEN, 8'h00);
      wr(OFS_POL, r.pol);
      wr(OFS_CTRL, {7'h0, r.mode} | 8'h06);
      wr(OFS_PEN, r.pen);
      tick(5);
      wr(OFS_CTRL, {7'h0, r.mode} | 8'h06);
      press <= r.act;
      tick(5);
      rd_check("ctrl", OFS_CTRL, {4'h0, r.f1, 2'h1, r.mode});
      check_bit("irq", r.f1, 1'h0);
      wr(OFS_CTRL, {7'h0, r.mode} | 8'h06);
      rd_check("ctrl ack", OFS_CTRL, {4'h0, r.f2, 2'h1, r.mode});
      press <= r.idle;
      tick(5);
    end
    wr(OFS_CTRL, 8'h04);
    rd_check("event", OFS_EVT, 8'h03);
    wr(OFS_MASK, 8'h01);
    check_bit("irq masked", 1'h1, 1'h0);
    wr(OFS_EVT, 8'h03);
    check_bit("irq cleared", 1'h0, 1'h0);
    wr(OFS_MASK, 8'h00);
    wr(OFS_CTRL, 8'h06);
    wait_mode <= 1'h1;
    press <= 4'hE;
    tick(5);
    check_bit("wake wait", 1'h1, 1'h1);
    tick(1);
    wait_mode <= 1'h0;
    press <= 4'hF;
    tick(5);
    wr(OFS_CTRL, 8'h06);
    light_stop_mode <= 1'h1;
    press <= 4'hE;
    tick(1);
    check_bit("wake light stop", 1'h1, 1'h1);
    tick(1);
    light_stop_mode <= 1'h0;
    press <= 4'hF;
    tick(5);
    wr(OFS_CTRL, 8'hFF);
    rd_check("ctrl fixed", OFS_CTRL, 8'h03);
    wr(8'h20, 8'hFF);
    rd_check("unmapped", 8'h20, 8'h00);
    deep_stop <= 1'h1;
    tick(2);
    deep_stop <= 1'h0;
    rd_check("pen deep stop", OFS_PEN, 8'h00);
    rd_check("ctrl deep stop", OFS_CTRL, 8'h00);
    wr(OFS_POL, 8'h0F);
    wr(OFS_PEN, 8'h0F);
    rst_b <= 1'h0;
    tick(2);
    rst_b <= 1'h1;
    rd_check("pen reset", OFS_PEN, 8'h00);
    rd_check("pol reset", OFS_POL, 8'h00);
    rd_check("ctrl reset", OFS_CTRL, 8'h00);
    check_bit("irq reset", 1'h0, 1'h0);
    complete_run;
  end
endmodule

// File: key_wakeup_pkg.sv
// constants, register map and types for the key wake-up interrupt block
// ---------------------------------------------------------------------
// Operation
// - eight independently enabled key inputs exist, four reach real pins.
// - a pin enable bit of 1 makes its input a source, 0 ignores it.
// - a polarity bit of 0 selects falling/low, 1 selects rising/high.
// - control bit 0 picks edge only (0) or edge plus level (1) detection.
// - control bit 3 shows the detect flag and writing bit 3 never changes it.
// - writing 1 to control bit 2 asks to clear the flag; it reads as 0.
// - control bit 1 gates the flag onto the interrupt request.
// - control bits 7:4 always read as zero.
// - in wait mode the block keeps working and an enabled source wakes.
// - in light stop an enabled, asserted input wakes without the clock.
// - in the deeper stops the block is off and wakes with its registers reset.
// - in background debug halt detection runs as in normal run.
// - an edge is deasserted in one cycle and asserted in the next.
// - after an edge, no new edge until all enabled inputs deassert.
// - in edge plus level mode an ack clears only with all deasserted.
// ---------------------------------------------------------------------
package key_wakeup_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int          LANES      = 8;
  localparam int          PINS       = 4;
  localparam int          REG_W      = 8;
  localparam int          ADR_W      = 8;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_PEN    = 8'h04;
  localparam logic [7:0]  OFS_POL    = 8'h08;
  localparam logic [7:0]  OFS_EVT    = 8'h0C;
  localparam logic [7:0]  OFS_MASK   = 8'h10;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int          BIT_MODE   = 0;
  localparam int          BIT_IE     = 1;
  localparam int          BIT_ACK    = 2;
  localparam int          BIT_FLAG   = 3;

  // event status / mask fields
  localparam int          EVT_DETECT = 0;
  localparam int          EVT_HELD   = 1;
  localparam int          EVT_W      = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_PEN    = 8'h00;
  localparam logic [7:0]  RST_POL    = 8'h00;
  localparam logic        RST_MODE   = 1'b0;
  localparam logic        RST_IE     = 1'b0;
  localparam logic        RST_FLAG   = 1'b0;
  localparam logic [1:0]  RST_EVT    = 2'h0;
  localparam logic [1:0]  RST_MASK   = 2'h0;

  typedef logic [LANES-1:0] lane_vec_t;

endpackage
